/* File: cif_pkg.sv */
// Package of constants and types for the CAN interrupt code and filter control block
package cif_pkg;
    // ------------------------------------------------------------------
    // Register map (byte addresses on AHB-Lite)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_IRQ_CODE = 8'h00;
    localparam logic [7:0] ADDR_FILTER_CTRL_2 = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] ADDR_HIT_CTRL = 8'h14;
    localparam logic [7:0] ADDR_FILTER_CFG = 8'h18;
    localparam int ADDR_W = 8;

    // ------------------------------------------------------------------
    // Interrupt codes and field layout
    // ------------------------------------------------------------------
    localparam logic [6:0] CODE_NONE = 7'h40;
    localparam logic [6:0] CODE_BUS_ERR = 7'h41;
    localparam logic [6:0] CODE_WAKEUP = 7'h42;
    localparam logic [6:0] CODE_RX_OVF = 7'h43;
    localparam logic [6:0] CODE_ADDR_ERR = 7'h44;
    localparam logic [6:0] CODE_BW_ERR = 7'h45;
    localparam logic [6:0] CODE_TIMESTAMP = 7'h46;
    localparam logic [6:0] CODE_MODE_CHG = 7'h47;
    localparam logic [6:0] CODE_INVALID = 7'h48;
    localparam int CODE_LSB = 0;
    localparam int HIT_LSB = 8;
    localparam int NUM_FIFO = 16;
    localparam int NUM_FILT = 16;

    // Filter control 2 field positions (filters 8..11, byte per filter)
    localparam int FLT_BASE = 8;
    localparam int FLT_PER_REG = 4;
    localparam int FSEL_LSB = 0;
    localparam int MSEL_LSB = 5;
    localparam int EN_BIT = 7;

    // Sticky status bit positions
    localparam int ST_BUS_ERR = 0;
    localparam int ST_WAKEUP = 1;
    localparam int ST_RX_OVF = 2;
    localparam int ST_ADDR_ERR = 3;
    localparam int ST_BW_ERR = 4;
    localparam int ST_TIMESTAMP = 5;
    localparam int ST_MODE_CHG = 6;
    localparam int ST_INVALID = 7;
    localparam int ST_MATCH = 8;
    localparam int NUM_EV = 9;

    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    // Per-filter configuration carried as a unit
    typedef struct packed {
        logic enable;
        logic [1:0] mask_sel;
        logic [4:0] fifo_sel;
    } cif_filter_t;

    // Module event inputs carried as a unit
    typedef struct packed {
        logic invalid_msg_flag;
        logic mode_change_flag;
        logic timestamp_timer_flag;
        logic bw_error;
        logic addr_error;
        logic rx_overflow_flag;
        logic wakeup_flag;
        logic bus_error_flag;
    } cif_events_t;
endpackage

/* File: cif_top.sv */
// Interrupt code register and filter control with an AHB-Lite register slave
// Functional notes
// - Bits 12:8 show matched filter number 0..15; codes 16..31 never reported.
// - Code n for pending FIFO n status; 1000000 when nothing pends.
// - Code lives in bits 6:0; reserved codes are never produced.
// - Bus error 1000001, wake-up 1000010, receive overflow 1000011.
// - Address error 1000100, bandwidth error 1000101, both system-error sources.
// - Timestamp 1000110, mode change 1000111, invalid message 1001000.
// - Bits 31:13 and bit 7 of the code register read zero.
// - Per-filter enable bit; filter 9 at bit 15, filter 8 at bit 7.
// - Two-bit mask select picks acceptance mask 0..3.
// - Five-bit FIFO select routes matches to FIFO 0..15; 16..31 reserved.
// - Mask and FIFO select bits change only while that filter's enable is zero.
module cif_top (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    input wire logic [cif_pkg::NUM_FIFO-1:0] fifo_irq_status_i,
    input wire cif_pkg::cif_events_t events_i,
    input wire logic msg_accept_i,
    input wire logic [3:0] msg_filter_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [cif_pkg::NUM_FILT*2-1:0] filter_mask_sel_o,
    output logic [cif_pkg::NUM_FILT*5-1:0] filter_fifo_sel_o,
    output logic [cif_pkg::NUM_FILT-1:0] filter_enable_o,
    output logic irq_o
);
    localparam int NUM_FIFO_W = 16;

    // ------------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------------
    logic wr_pend_r;
    logic [cif_pkg::ADDR_W-1:0] wr_addr_r;
    logic addr_ok;
    assign addr_ok = hsel_i && hready_i && (htrans_i == cif_pkg::HTRANS_NONSEQ);

    // Zero-wait slave: every transfer completes in its first data cycle
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= '0;
        end
        else
        begin
            wr_pend_r <= addr_ok && hwrite_i;
            wr_addr_r <= haddr_i[cif_pkg::ADDR_W-1:0];
        end
    end

    // Always ready and OKAY; registered so outputs come from flops
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
        else
        begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Filter configuration
    // ------------------------------------------------------------------
    cif_pkg::cif_filter_t filt_r [cif_pkg::NUM_FILT];
    logic [3:0] cfg_sel_r;
    logic [3:0] cfg_sel_nxt;
    logic wr_fc2;
    logic wr_cfg;
    assign wr_fc2 = wr_pend_r && (wr_addr_r == cif_pkg::ADDR_FILTER_CTRL_2);
    assign wr_cfg = wr_pend_r && (wr_addr_r == cif_pkg::ADDR_FILTER_CFG);
    assign cfg_sel_nxt = hwdata_i[11:8];

    // Generic window: pick a filter with bits 11:8, then bits 7:0 write it
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            cfg_sel_r <= '0;
        else if (wr_pend_r && (wr_addr_r == cif_pkg::ADDR_HIT_CTRL))
            cfg_sel_r <= cfg_sel_nxt;
    end

    genvar g;
    generate
        for (g = 0; g < cif_pkg::NUM_FILT; g++)
        begin : g_filt
            localparam bit IN_FC2 = (g >= cif_pkg::FLT_BASE) &&
                (g < cif_pkg::FLT_BASE + cif_pkg::FLT_PER_REG);
            localparam int SL = (g - cif_pkg::FLT_BASE) * 8;
            logic hit_fc2;
            logic hit_cfg;
            cif_pkg::cif_filter_t wval;
            assign hit_fc2 = IN_FC2 && wr_fc2;
            assign hit_cfg = wr_cfg && (cfg_sel_r == 4'(g));
            assign wval = hit_fc2 ? cif_pkg::cif_filter_t'(hwdata_i[(IN_FC2 ? SL : 0) +: 8])
                                  : cif_pkg::cif_filter_t'(hwdata_i[7:0]);

            // Locked while enabled: only the enable bit itself may change
            always_ff @(posedge sys_clk_i or posedge rst_i)
            begin
                if (rst_i)
                    filt_r[g] <= '0;
                else if (hit_fc2 || hit_cfg)
                begin
                    filt_r[g].enable <= wval.enable;
                    if (!filt_r[g].enable)
                    begin
                        filt_r[g].mask_sel <= wval.mask_sel;
                        filt_r[g].fifo_sel <= wval.fifo_sel;
                    end
                end
            end

            // Outputs toward the matching engine
            always_ff @(posedge sys_clk_i or posedge rst_i)
            begin
                if (rst_i)
                begin
                    filter_enable_o[g] <= 1'b0;
                    filter_mask_sel_o[g*2 +: 2] <= '0;
                    filter_fifo_sel_o[g*5 +: 5] <= '0;
                end
                else
                begin
                    filter_enable_o[g] <= filt_r[g].enable;
                    filter_mask_sel_o[g*2 +: 2] <= filt_r[g].mask_sel;
                    filter_fifo_sel_o[g*5 +: 5] <= filt_r[g].fifo_sel;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Filter hit capture
    // ------------------------------------------------------------------
    logic [4:0] hit_r;
    // Index is four bits wide, so reserved values 16..31 cannot appear
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            hit_r <= '0;
        else if (msg_accept_i && filt_r[msg_filter_i].enable)
            hit_r <= {1'b0, msg_filter_i};
    end

    // ------------------------------------------------------------------
    // Sticky status, enable and clear
    // ------------------------------------------------------------------
    logic [cif_pkg::NUM_EV-1:0] status_r;
    logic [cif_pkg::NUM_EV-1:0] irq_en_r;
    logic [cif_pkg::NUM_EV-1:0] ev_in;
    logic [cif_pkg::NUM_EV-1:0] clr_mask;
    assign ev_in = {msg_accept_i, events_i};
    assign clr_mask = (wr_pend_r && (wr_addr_r == cif_pkg::ADDR_IRQ_CLEAR)) ?
        hwdata_i[cif_pkg::NUM_EV-1:0] : '0;

    // Set wins over a clear in the same cycle
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            status_r <= '0;
        else
            status_r <= (status_r & ~clr_mask) | ev_in;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            irq_en_r <= '0;
        else if (wr_pend_r && (wr_addr_r == cif_pkg::ADDR_IRQ_ENABLE))
            irq_en_r <= hwdata_i[cif_pkg::NUM_EV-1:0];
    end

    // ------------------------------------------------------------------
    // Interrupt code priority encoder
    // ------------------------------------------------------------------
    logic [6:0] code_nxt;
    // FIFOs first, lowest number winning, then module events in code order
    always_comb
    begin
        code_nxt = cif_pkg::CODE_NONE;
        if (status_r[cif_pkg::ST_INVALID])
            code_nxt = cif_pkg::CODE_INVALID;
        if (status_r[cif_pkg::ST_MODE_CHG])
            code_nxt = cif_pkg::CODE_MODE_CHG;
        if (status_r[cif_pkg::ST_TIMESTAMP])
            code_nxt = cif_pkg::CODE_TIMESTAMP;
        if (status_r[cif_pkg::ST_BW_ERR])
            code_nxt = cif_pkg::CODE_BW_ERR;
        if (status_r[cif_pkg::ST_ADDR_ERR])
            code_nxt = cif_pkg::CODE_ADDR_ERR;
        if (status_r[cif_pkg::ST_RX_OVF])
            code_nxt = cif_pkg::CODE_RX_OVF;
        if (status_r[cif_pkg::ST_WAKEUP])
            code_nxt = cif_pkg::CODE_WAKEUP;
        if (status_r[cif_pkg::ST_BUS_ERR])
            code_nxt = cif_pkg::CODE_BUS_ERR;
        for (int i = NUM_FIFO_W - 1; i >= 0; i--)
        begin
            if (fifo_irq_status_i[i])
                code_nxt = 7'(i);
        end
    end

    logic [6:0] code_r;
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            code_r <= cif_pkg::CODE_NONE;
        else
            code_r <= code_nxt;
    end

    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            irq_o <= 1'b0;
        else
            irq_o <= |(status_r & irq_en_r);
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [31:0] rd_nxt;
    // Decoded in the address phase so the word stands through the data phase
    always_comb
    begin
        rd_nxt = cif_pkg::ZERO_WORD;
        unique case (haddr_i[cif_pkg::ADDR_W-1:0])
            cif_pkg::ADDR_IRQ_CODE:
                rd_nxt = {19'h0, hit_r, 1'b0, code_r};
            cif_pkg::ADDR_FILTER_CTRL_2:
                rd_nxt = {filt_r[11], filt_r[10], filt_r[9], filt_r[8]};
            cif_pkg::ADDR_IRQ_STATUS:
                rd_nxt = {23'h0, status_r};
            cif_pkg::ADDR_IRQ_ENABLE:
                rd_nxt = {23'h0, irq_en_r};
            cif_pkg::ADDR_HIT_CTRL:
                rd_nxt = {20'h0, cfg_sel_r, 8'h00};
            cif_pkg::ADDR_FILTER_CFG:
                rd_nxt = {24'h0, filt_r[cfg_sel_r]};
            default:
                rd_nxt = cif_pkg::ZERO_WORD;
        endcase
    end

    // Loaded at the address edge, held until the next read; a read issued
    // right behind a write's address phase sees the value before that write
    always_ff @(posedge sys_clk_i or posedge rst_i)
    begin
        if (rst_i)
            hrdata_o <= '0;
        else if (addr_ok && !hwrite_i)
            hrdata_o <= rd_nxt;
    end
endmodule // cif_top

/* File: cif_chk.sv */
// Checker for the interrupt code and filter control ports
module cif_chk (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [31:0] filter_mask_sel_o,
    input wire logic [79:0] filter_fifo_sel_o,
    input wire logic [15:0] filter_enable_o
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i);
    // Code register read taken; its data is registered one edge on
    sequence code_rd;
        hsel_i && hready_i && htrans_i == cif_pkg::HTRANS_NONSEQ && !hwrite_i
            && haddr_i == 32'h0000_0000;
    endsequence
    a_resp_okay: assert property (!hresp_o)
        else $error("response is not OKAY");
    a_zero_wait: assert property (hreadyout_o)
        else $error("wait state inserted");
    a_code_pad_zero: assert property (code_rd |-> ##1 hrdata_o[31:13] == 19'h0_0000 && !hrdata_o[7])
        else $error("code register padding not zero");
    a_code_legal: assert property (code_rd |-> ##1 (hrdata_o[6:0] < 7'h10
        || (hrdata_o[6:0] >= 7'h40 && hrdata_o[6:0] <= 7'h48)))
        else $error("reserved interrupt code");
    a_hit_range: assert property (code_rd |-> ##1 !hrdata_o[12])
        else $error("reserved filter hit number");
    // Selection may only move while the filter was off
    a_fifo8_locked: assert property ($changed(filter_fifo_sel_o[44:40]) |-> !$past(filter_enable_o[8]))
        else $error("filter 8 fifo select changed while enabled");
    a_fifo9_locked: assert property ($changed(filter_fifo_sel_o[49:45]) |-> !$past(filter_enable_o[9]))
        else $error("filter 9 fifo select changed while enabled");
    a_mask9_locked: assert property ($changed(filter_mask_sel_o[19:18]) |-> !$past(filter_enable_o[9]))
        else $error("filter 9 mask select changed while enabled");
endmodule // cif_chk

bind cif_top cif_chk i_cif_chk (.sys_clk_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .filter_mask_sel_o, .filter_fifo_sel_o,
    .filter_enable_o);

/* File: can_irq_code_and_filter_ctrl_tb_top.sv */
// Self-checking bench of the interrupt code and filter control block
module can_irq_code_and_filter_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [7:0] ev; logic [6:0] code; } cif_row_t;
    // Event pulse beside the code it must give; last row checks priority
    cif_row_t rows [9] = '{'{8'h01, 7'h41}, '{8'h02, 7'h42}, '{8'h04, 7'h43},
        '{8'h08, 7'h44}, '{8'h10, 7'h45}, '{8'h20, 7'h46}, '{8'h40, 7'h47},
        '{8'h80, 7'h48}, '{8'h81, 7'h41}};
    logic sys_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hwrite_i = 1'b0;
    logic msg_accept_i = 1'b0;
    logic [1:0] htrans_i = 2'h0;
    logic [31:0] haddr_i = 32'h0000_0000;
    logic [31:0] hwdata_i = 32'h0000_0000;
    logic [15:0] fifo_irq_status_i = 16'h0000;
    logic [7:0] events_i = 8'h00;
    logic [3:0] msg_filter_i = 4'h0;
    logic [31:0] hrdata_o, rd;
    logic [31:0] filter_mask_sel_o;
    logic [79:0] filter_fifo_sel_o;
    logic [15:0] filter_enable_o;
    logic hreadyout_o, hresp_o, irq_o;
    int fail_count = 0;
    int tests_run = 0;
    int cyc = 0;

    always #12.5 sys_clk_i = ~sys_clk_i;

    cif_top i_cif_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .hsel_i(1'b1), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .fifo_irq_status_i(fifo_irq_status_i), .events_i(events_i),
        .msg_accept_i(msg_accept_i), .msg_filter_i(msg_filter_i), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .filter_mask_sel_o(filter_mask_sel_o),
        .filter_fifo_sel_o(filter_fifo_sel_o), .filter_enable_o(filter_enable_o), .irq_o(irq_o));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Hang guard, well above the few hundred cycles needed
    always @(posedge sys_clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One single transfer; read data taken at the edge ending the data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        htrans_i <= cif_pkg::HTRANS_NONSEQ;
        hwrite_i <= wr;
        haddr_i <= {24'h00_0000, a};
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        rd = hrdata_o;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
        bus(1'b0, a, 32'h0000_0000);
        chk(nm, exp, rd);
    endtask
    task automatic pulse(input logic [7:0] ev, input logic acc, input logic [3:0] f);
        @(posedge sys_clk_i);
        events_i <= ev;
        msg_accept_i <= acc;
        msg_filter_i <= f;
        @(posedge sys_clk_i);
        events_i <= 8'h00;
        msg_accept_i <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdc(8'h00, 32'h0000_0040, "code at reset");
        rdc(8'h40, 32'h0000_0000, "unmapped");
        bus(1'b1, 8'h10, 32'h0000_01FF);
        foreach (rows[i])
        begin
            pulse(rows[i].ev, 1'b0, 4'h0);
            rdc(8'h00, {25'h0, rows[i].code}, "event code");
            chk("irq raised", 32'h1, {31'h0, irq_o});
            bus(1'b1, 8'h0C, 32'h0000_01FF);
            rdc(8'h00, 32'h0000_0040, "code cleared");
        end
        // Masked event leaves the line low until enabled
        bus(1'b1, 8'h10, 32'h0000_0000);
        pulse(8'h04, 1'b0, 4'h0);
        rdc(8'h08, 32'h0000_0004, "status");
        chk("irq masked", 32'h0, {31'h0, irq_o});
        bus(1'b1, 8'h10, 32'h0000_0004);
        rdc(8'h10, 32'h0000_0004, "enable");
        chk("irq enabled", 32'h1, {31'h0, irq_o});
        // FIFO codes outrank the pending overflow event
        for (int n = 0; n < 16; n++)
        begin
            @(posedge sys_clk_i);
            fifo_irq_status_i <= 16'h8000 | (16'h0001 << n);
            rdc(8'h00, n, "fifo code");
        end
        @(posedge sys_clk_i);
        fifo_irq_status_i <= 16'h0000;
        rdc(8'h00, 32'h0000_0043, "next source");
        bus(1'b1, 8'h0C, 32'h0000_01FF);
        rdc(8'h00, 32'h0000_0040, "none pending");
        chk("irq cleared", 32'h0, {31'h0, irq_o});
        // Filter fields, hit index, then write lock on enabled filter
        bus(1'b1, 8'h04, 32'h000A_C56F);
        rdc(8'h04, 32'h000A_C56F, "filter ctrl");
        chk("enables", 32'h0000_0200, {16'h0, filter_enable_o});
        chk("mask sel", 32'h0000_000B, {26'h0, filter_mask_sel_o[21:16]});
        chk("fifo sel", 32'h0000_28AF, {17'h0, filter_fifo_sel_o[54:40]});
        pulse(8'h00, 1'b1, 4'h9);
        rdc(8'h00, 32'h0000_0940, "filter hit");
        bus(1'b1, 8'h04, 32'h0000_0000);
        rdc(8'h04, 32'h0000_4500, "locked fields");
        // Reset in mid-run clears configuration
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        rdc(8'h04, 32'h0000_0000, "ctrl after reset");
        rdc(8'h00, 32'h0000_0040, "code after reset");
        give_verdict();
    end
endmodule // can_irq_code_and_filter_ctrl_tb_top
